//--- bench/rso_dbg_host.sv
// debug host model driving the shared debug pin after a forced reset
module rso_dbg_host
#(
  parameter int HOLD_PIN = 12 // cycles the mode level is held
)
(
  input wire logic core_clk, // bus clock
  input wire logic issued,   // force command being sent
  input wire logic want_bdm, // ask for background debug mode
  output logic pin_level     // shared debug pin level
);
  int cnt = 0;
  // keep the mode level through the reset, then the pullup wins
  always @(posedge core_clk) begin
    if (issued) begin
      cnt <= HOLD_PIN;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign pin_level = (issued || cnt > 0) ? ~want_bdm : 1'b1;
endmodule

//--- bench/rso_top_asserts.sv
// port-level assertions for the reset status and options block
module rso_top_asserts
  import rso_pkg::*;
#(
  parameter int HOLD_CYCLES = 2 // length of the internal reset pulse
)
(
  input wire logic core_clk,                 // bus clock
  input wire logic rst,                      // power-on reset
  input wire logic acc_en,                   // access strobe
  input wire logic acc_we,                   // write access
  input wire logic acc_from_debug,           // debug command access
  input wire logic [1:0] acc_sel,            // register index
  input wire logic [7:0] acc_wdata,          // write data
  input wire logic watchdog_timeout,         // watchdog expired
  input wire logic illegal_opcode,           // bad opcode
  input wire logic illegal_address,          // bad address
  input wire logic exec_sleep,               // sleep executed
  input wire logic [7:0] acc_rdata,          // read data
  input wire logic mcu_reset,                // device in reset
  input wire logic watchdog_restart,         // restart pulse
  input wire logic watchdog_enable,          // options bit 7
  input wire logic watchdog_timeout_select,  // options bit 6
  input wire logic sleep_permit,             // options bit 5
  input wire logic debug_pin_enable,         // options bit 1
  input wire logic reset_pin_enable,         // options bit 0
  input wire logic reset_pin_pullup,         // pullup on reset pin
  input wire logic [7:0] reset_cause_status  // cause flags
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // write taken in run; pending watchdog, illegal opcode, illegal address and sleep sources are excluded by quiet, not here
  wire logic wr_ok = acc_en && acc_we && !mcu_reset;
  wire logic quiet = !watchdog_timeout && !illegal_opcode && !illegal_address && !exec_sleep;
  wire logic frc = wr_ok && acc_from_debug && acc_sel == REG_IDX_FORCE && acc_wdata[0];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_status_unimpl: assert property (
    reset_cause_status[2] == 1'b0 && reset_cause_status[0] == 1'b0) else $error("status spare bits set");
  a_pullup_follows: assert property (
    reset_pin_pullup == reset_pin_enable) else $error("pullup differs from reset pin enable");
  a_reset_defaults: assert property (disable iff (1'b0) rst |=> mcu_reset && watchdog_enable &&
    debug_pin_enable && !sleep_permit) else $error("option defaults wrong in reset");
  a_restart_pulse: assert property (
    wr_ok && acc_sel == REG_IDX_STATUS |=> watchdog_restart) else $error("no watchdog restart");
  a_status_kept: assert property (
    wr_ok && acc_sel == REG_IDX_STATUS && quiet |=> $stable(reset_cause_status)) else $error("status changed");
  a_force_reads_zero: assert property (
    acc_en && !acc_we && acc_sel == REG_IDX_FORCE |=> acc_rdata == 8'h00) else $error("force reg read not zero");
  a_force_resets: assert property (
    frc |=> mcu_reset) else $error("debug force did not reset");
  a_force_clears: assert property (
    frc |-> ##[2:3] reset_cause_status == 8'h00) else $error("force reset left flags set");
  a_user_force_ign: assert property (
    wr_ok && !acc_from_debug && acc_sel == REG_IDX_FORCE && quiet |=> !mcu_reset) else $error("user force acted");
  a_wdog_blocked: assert property (
    watchdog_timeout && !watchdog_enable && !mcu_reset && !illegal_opcode && !illegal_address && !exec_sleep
    |=> !mcu_reset) else $error("disabled watchdog reset");
  a_sleep_illegal: assert property (
    exec_sleep && !sleep_permit && !mcu_reset |=> mcu_reset) else $error("blocked sleep did not reset");
  a_rdata_opts: assert property (
    acc_en && !acc_we && acc_sel == REG_IDX_OPTS && !mcu_reset |=> (acc_rdata & 8'he3) ==
    {watchdog_enable, watchdog_timeout_select, sleep_permit, 3'h0, debug_pin_enable, reset_pin_enable})
    else $error("options read differs from outputs");
endmodule

//--- bench/tb_top.sv
// self-checking bench for the reset status and options block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rso_pkg::*;
  typedef struct packed {logic [6:0] src; logic [7:0] st; logic [7:0] opt;} rso_row_t;
  // source mask: 0 wdog, 1 illegal_opcode_flag, 2 illegal_address_flag, 3 sleep, 4 background, 5 pin, 6 low voltage
  localparam rso_row_t ROWS [8] = '{
    '{7'h01, 8'h20, 8'hd3},
    '{7'h02, 8'h10, 8'hd3},
    '{7'h04, 8'h08, 8'hd3},
    '{7'h06, 8'h18, 8'hd3},
    '{7'h08, 8'h10, 8'hd3},
    '{7'h10, 8'h10, 8'hd3},
    '{7'h20, 8'h40, 8'hd3},
    '{7'h40, 8'h02, 8'hd2}};
  logic core_clk, rst, acc_en, acc_we, acc_from_debug, low_voltage_trip, shared_reset_pin_level;
  logic shared_debug_pin_level, watchdog_timeout, illegal_opcode, exec_sleep, exec_background, illegal_address;
  logic mcu_reset, watchdog_restart, watchdog_enable, watchdog_timeout_select, sleep_permit, sleep_enter;
  logic debug_pin_enable, reset_pin_enable, reset_pin_pullup, background_debug_mode, pulse, issued, want_bdm;
  logic [1:0] acc_sel;
  logic [7:0] acc_wdata, acc_rdata, reset_cause_status;
  logic lvd_en, bg_en;
  int err_count, tests_run, cyc;

  rso_top #(.HOLD_CYCLES(2)) i_dut (.core_clk, .rst, .acc_en, .acc_we, .acc_from_debug, .acc_sel,
    .acc_wdata, .low_voltage_trip, .low_voltage_reset_enable(lvd_en), .shared_reset_pin_level,
    .shared_debug_pin_level, .watchdog_timeout, .illegal_opcode, .exec_sleep, .exec_background,
    .background_mode_enable(bg_en), .illegal_address, .acc_rdata, .mcu_reset, .watchdog_restart,
    .watchdog_enable, .watchdog_timeout_select, .sleep_permit, .sleep_enter, .debug_pin_enable,
    .reset_pin_enable, .reset_pin_pullup, .background_debug_mode, .reset_cause_status);
  rso_dbg_host i_host (.core_clk, .issued, .want_bdm, .pin_level(shared_debug_pin_level));

  // ---------------------------------------------------------------
  // clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one access strobe; pulse keeps the restart output of the cycle after it
  task automatic acc(input logic we, input logic dbg, input logic [1:0] sel, input logic [7:0] wd);
    @(negedge core_clk);
    acc_en = 1'b1;
    acc_we = we;
    acc_from_debug = dbg;
    acc_sel = sel;
    acc_wdata = wd;
    issued = dbg && we && sel == REG_IDX_FORCE;
    @(negedge core_clk);
    acc_en = 1'b0;
    issued = 1'b0;
    pulse = watchdog_restart;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [1:0] sel, input logic [7:0] exp, input string what);
    acc(1'b0, 1'b0, sel, 8'h00);
    chk(what, acc_rdata, exp);
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (mcu_reset !== 1'b0 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 200) err_count++;
  endtask
  task automatic fire(input logic [6:0] m);
    @(negedge core_clk);
    {low_voltage_trip, exec_background, exec_sleep, illegal_address, illegal_opcode, watchdog_timeout} =
      {m[6], m[4:0]};
    shared_reset_pin_level = ~m[5];
    @(negedge core_clk);
    {exec_background, exec_sleep, illegal_address, illegal_opcode, watchdog_timeout} = 5'h00;
    repeat (4) @(negedge core_clk);
    shared_reset_pin_level = 1'b1;
    low_voltage_trip = 1'b0;
    wait_run();
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, issued, want_bdm, shared_reset_pin_level, low_voltage_trip} = 5'b10010;
    {acc_en, acc_we, acc_from_debug, acc_sel, acc_wdata} = '0;
    {watchdog_timeout, illegal_opcode, exec_sleep, exec_background, illegal_address} = 5'h00;
    {lvd_en, bg_en} = 2'b10;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    wait_run();
    acc(1'b1, 1'b0, REG_IDX_OPTS, 8'hd3);
    acc(1'b1, 1'b0, REG_IDX_OPTS, 8'h00);
    rd(REG_IDX_OPTS, 8'hd3, "options once");
    $display("write once test done");
    foreach (ROWS[i]) begin
      fire(ROWS[i].src);
      rd(REG_IDX_STATUS, ROWS[i].st, "status");
      chk("status copy", reset_cause_status, ROWS[i].st);
      rd(REG_IDX_OPTS, ROWS[i].opt, "options after reset");
      $display("cause row %0d done", i);
    end
    acc(1'b1, 1'b0, REG_IDX_STATUS, 8'hff);
    chk("restart", {7'h00, pulse}, 8'h01);
    rd(REG_IDX_STATUS, 8'h02, "status after write");
    acc(1'b1, 1'b0, REG_IDX_FORCE, 8'h01);
    chk("user force", {7'h00, mcu_reset}, 8'h00);
    acc(1'b1, 1'b0, REG_IDX_OPTS, 8'h73);
    rd(REG_IDX_OPTS, 8'h73, "options written");
    chk("option pins", {2'h0, watchdog_enable, watchdog_timeout_select, sleep_permit, debug_pin_enable,
      reset_pin_enable, reset_pin_pullup}, 8'h1f);
    @(negedge core_clk);
    watchdog_timeout = 1'b1;
    @(negedge core_clk);
    watchdog_timeout = 1'b0;
    exec_sleep = 1'b1;
    @(negedge core_clk);
    exec_sleep = 1'b0;
    chk("sleep grant", {7'h00, sleep_enter}, 8'h01);
    repeat (3) @(negedge core_clk);
    chk("no reset", {7'h00, mcu_reset}, 8'h00);
    {lvd_en, bg_en, exec_background, low_voltage_trip} = 4'b0111;
    @(negedge core_clk);
    exec_background = 1'b0;
    repeat (4) @(negedge core_clk);
    low_voltage_trip = 1'b0;
    chk("enables off", {7'h00, mcu_reset}, 8'h00);
    $display("options test done");
    for (int b = 1; b >= 0; b--) begin
      want_bdm = b[0];
      acc(1'b1, 1'b1, REG_IDX_FORCE, 8'h01);
      chk("forced reset", {7'h00, mcu_reset}, 8'h01);
      wait_run();
      rd(REG_IDX_STATUS, 8'h00, "status after force");
      chk("debug mode", {7'h00, background_debug_mode}, {7'h00, b[0]});
      rd(REG_IDX_OPTS, 8'hd3, "options after force");
    end
    $display("force test done");
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    wait_run();
    rd(REG_IDX_STATUS, 8'h82, "status power-on");
    rd(REG_IDX_OPTS, 8'hd2, "options power-on");
    rd(REG_IDX_FORCE, 8'h00, "force read");
    rd(2'h3, 8'h00, "unmapped read");
    $display("power-on test done");
    tally_and_finish();
  end
endmodule

bind rso_top rso_top_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (.core_clk, .rst, .acc_en, .acc_we,
  .acc_from_debug, .acc_sel, .acc_wdata, .watchdog_timeout, .illegal_opcode, .illegal_address, .exec_sleep,
  .acc_rdata, .mcu_reset, .watchdog_restart, .watchdog_enable, .watchdog_timeout_select, .sleep_permit,
  .debug_pin_enable, .reset_pin_enable, .reset_pin_pullup, .reset_cause_status);

//--- hdl/rso_cause_latch.sv
// reset cause status store
module rso_cause_latch
  import rso_pkg::*;
(
  input wire logic core_clk, // bus clock
  input wire logic rst,      // power-on reset
  rso_if.cause_mp cz         // capture request and status
);
  logic [7:0] status_reg;
  logic [7:0] status_next;

  // next status on reset entry
  always_comb begin
    status_next = cz.cause_src & STATUS_MASK;
    status_next[ST_POR] = 1'b0;
    if (cz.lvd_src) begin
      status_next[ST_LVD] = 1'b1;
      status_next[ST_POR] = status_reg[ST_POR];
    end
    if (cz.forced) begin
      status_next = STATUS_CLR_VAL;
    end
  end

  // status register, loaded only at reset entry
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= STATUS_POR_VAL;
    end else if (cz.cap) begin
      status_reg <= status_next;
    end
  end

  assign cz.status = status_reg & STATUS_MASK;
endmodule

//--- hdl/rso_if.sv
// carrier between the sequencer and its cause and options stores
interface rso_if;
  logic cap;
  logic forced;
  logic lvd_src;
  logic [7:0] cause_src;
  logic [7:0] status;
  logic opt_init;
  logic opt_full;
  logic opt_wr;
  logic [7:0] opt_wdata;
  logic [7:0] opt_val;
  logic opt_written;
  modport ctl_mp (output cap, forced, lvd_src, cause_src, opt_init, opt_full, opt_wr, opt_wdata,
                  input status, opt_val, opt_written);
  modport cause_mp (input cap, forced, lvd_src, cause_src, output status);
  modport opts_mp (input opt_init, opt_full, opt_wr, opt_wdata, output opt_val, opt_written);
endinterface

//--- hdl/rso_opts_once.sv
// write-once system options store
module rso_opts_once
  import rso_pkg::*;
(
  input wire logic core_clk, // bus clock
  input wire logic rst,      // power-on reset
  rso_if.opts_mp op          // init and write requests
);
  logic [7:0] opt_reg;
  logic written_reg;

  // value: full init on power-on or low voltage, reset pin bit kept otherwise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      opt_reg <= OPT_RESET_VAL;
    end else if (op.opt_init) begin
      opt_reg <= OPT_RESET_VAL;
      if (!op.opt_full) begin
        opt_reg[OPT_RST_PIN] <= opt_reg[OPT_RST_PIN];
      end
    end else if (op.opt_wr && !written_reg) begin
      opt_reg <= op.opt_wdata & OPT_MASK;
    end
  end

  // one write allowed per reset
  always_ff @(posedge core_clk) begin
    if (rst || op.opt_init) begin
      written_reg <= 1'b0;
    end else if (op.opt_wr) begin
      written_reg <= 1'b1;
    end
  end

  assign op.opt_val = opt_reg & OPT_MASK;
  assign op.opt_written = written_reg;
endmodule

//--- hdl/rso_pkg.sv
// constants and types shared by the reset status and options block
package rso_pkg;

  // ---------------------------------------------------------------
  // clock and reset hold timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int RESET_HOLD_NS = 1000;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HOLD_W = 8;

  // ---------------------------------------------------------------
  // register indices on the access port
  // ---------------------------------------------------------------
  localparam logic [1:0] REG_IDX_STATUS = 2'h0;
  localparam logic [1:0] REG_IDX_FORCE = 2'h1;
  localparam logic [1:0] REG_IDX_OPTS = 2'h2;

  // ---------------------------------------------------------------
  // reset cause status fields
  // ---------------------------------------------------------------
  localparam int ST_POR = 7;
  localparam int ST_PIN = 6;
  localparam int ST_WDOG = 5;
  localparam int ST_ILLEGAL_OPCODE_FLAG = 4;
  localparam int ST_ILLEGAL_ADDRESS_FLAG = 3;
  localparam int ST_LVD = 1;
  localparam logic [7:0] STATUS_MASK = 8'hfa;
  localparam logic [7:0] STATUS_POR_VAL = 8'h82;
  localparam logic [7:0] STATUS_CLR_VAL = 8'h00;

  // ---------------------------------------------------------------
  // force reset register
  // ---------------------------------------------------------------
  localparam int FORCE_BIT = 0;
  localparam logic [7:0] FORCE_READ_VAL = 8'h00;

  // ---------------------------------------------------------------
  // write-once options fields
  // ---------------------------------------------------------------
  localparam int OPT_WDOG_EN = 7;
  localparam int OPT_WDOG_TSEL = 6;
  localparam int OPT_SLEEP = 5;
  localparam int OPT_RSVD = 4;
  localparam int OPT_DBG_PIN = 1;
  localparam int OPT_RST_PIN = 0;
  localparam logic [7:0] OPT_MASK = 8'hf3;
  localparam logic [7:0] OPT_RESET_VAL = 8'hd2;

  // reset sequencer states
  typedef enum logic [1:0] {RSO_RUN, RSO_HOLD, RSO_RELEASE} rso_state_t;

endpackage

//--- hdl/rso_top.sv
// reset cause status, debug force reset and write-once options
module rso_top
  import rso_pkg::*;
#(
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES // length of the internal reset pulse
)
(
  input wire logic core_clk,                  // bus clock
  input wire logic rst,                       // power-on reset
  input wire logic acc_en,                    // register access strobe
  input wire logic acc_we,                    // access is a write
  input wire logic acc_from_debug,            // access made by a background command
  input wire logic [1:0] acc_sel,             // register index
  input wire logic [7:0] acc_wdata,           // write data
  input wire logic low_voltage_trip,          // supply below trip level, async
  input wire logic low_voltage_reset_enable,  // trip causes reset
  input wire logic shared_reset_pin_level,    // raw level of the shared reset pin, async
  input wire logic shared_debug_pin_level,    // raw level of the shared debug pin, async
  input wire logic watchdog_timeout,          // watchdog counter expired
  input wire logic illegal_opcode,            // unimplemented opcode attempted
  input wire logic exec_sleep,                // sleep instruction executed
  input wire logic exec_background,           // background instruction executed
  input wire logic background_mode_enable,    // active background mode allowed
  input wire logic illegal_address,           // unimplemented address accessed
  output logic [7:0] acc_rdata,               // read data, one cycle after strobe
  output logic mcu_reset,                     // device held in reset
  output logic watchdog_restart,              // watchdog restart, one cycle per status write and high while in reset
  output logic watchdog_enable,               // watchdog may reset the device
  output logic watchdog_timeout_select,       // long timeout when high
  output logic sleep_permit,                  // sleep instruction allowed
  output logic sleep_enter,                   // one-cycle sleep grant pulse
  output logic debug_pin_enable,              // debug pin has the debug function
  output logic reset_pin_enable,              // reset pin acts as reset input
  output logic reset_pin_pullup,              // internal pullup on the reset pin
  output logic background_debug_mode,         // start in background debug mode
  output logic [7:0] reset_cause_status       // copy of the cause flags
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rso_if bus ();

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] async_in;
  logic lvd_sync;
  logic pin_sync;
  logic dbg_sync;
  localparam logic [2:0] SYNC_IDLE = 3'b110; // idle levels: pins high, supply fine

  rso_state_t state_reg;
  rso_state_t state_next;
  logic [HOLD_W-1:0] hold_reg;

  logic src_lvd;
  logic src_pin;
  logic src_wdog;
  logic src_illegal_opcode_flag;
  logic src_illegal_address_flag;
  logic src_force;
  logic any_src;
  logic hold_src;

  logic wr_status;
  logic wr_force;
  logic wr_opts;
  logic rd_any;
  logic [7:0] rdata_next;

  logic forced_reg;
  logic lvd_entry_reg;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------

  // decoder used by the write strobes; the read mux decodes acc_sel itself
  function automatic logic sel_hit(input logic [1:0] sel, input logic [1:0] idx);
    sel_hit = (sel == idx);
  endfunction

  // writes are refused while the device is held in reset; reads are not
  assign wr_status = acc_en && acc_we && sel_hit(acc_sel, REG_IDX_STATUS) && state_reg == RSO_RUN;
  assign wr_force = acc_en && acc_we && acc_from_debug && sel_hit(acc_sel, REG_IDX_FORCE)
                    && state_reg == RSO_RUN;
  assign wr_opts = acc_en && acc_we && sel_hit(acc_sel, REG_IDX_OPTS) && state_reg == RSO_RUN;
  assign rd_any = acc_en && !acc_we;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  assign async_in = {shared_debug_pin_level, shared_reset_pin_level, low_voltage_trip};

  // two flops per asynchronous input; reset to idle so no false source follows reset
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (rst) begin
          sync1_reg[gi] <= SYNC_IDLE[gi];
          sync2_reg[gi] <= SYNC_IDLE[gi];
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign lvd_sync = sync2_reg[0] & ~rst;
  assign pin_sync = sync2_reg[1];
  assign dbg_sync = sync2_reg[2];

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------

  // low voltage, pin, watchdog, sleep and background sources are qualified by their enables
  assign src_lvd = lvd_sync && low_voltage_reset_enable;
  assign src_pin = !pin_sync && bus.opt_val[OPT_RST_PIN];
  assign src_wdog = watchdog_timeout && bus.opt_val[OPT_WDOG_EN];
  assign src_illegal_opcode_flag = illegal_opcode
                    || (exec_sleep && !bus.opt_val[OPT_SLEEP])
                    || (exec_background && !background_mode_enable);
  assign src_illegal_address_flag = illegal_address;
  assign src_force = wr_force && acc_wdata[FORCE_BIT];

  assign any_src = src_lvd || src_pin || src_wdog || src_illegal_opcode_flag || src_illegal_address_flag || src_force;

  // sources that keep the device in reset while they last
  assign hold_src = src_lvd || src_pin;

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RSO_RUN: begin
        if (any_src) begin
          state_next = RSO_HOLD;
        end
      end
      RSO_HOLD: begin
        if (hold_reg == '0 && !hold_src) begin
          state_next = RSO_RELEASE;
        end
      end
      RSO_RELEASE: begin
        state_next = RSO_RUN;
      end
      default: begin
        state_next = RSO_HOLD;
      end
    endcase
  end

  // state register; power-on starts a hold
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= RSO_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // hold counter sets the length of the internal reset pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_reg <= HOLD_W'(HOLD_CYCLES - 1);
    end else if (state_reg == RSO_RUN && any_src) begin
      hold_reg <= HOLD_W'(HOLD_CYCLES - 1);
    end else if (state_reg == RSO_HOLD && hold_reg != '0) begin
      hold_reg <= hold_reg - HOLD_W'(1);
    end
  end

  // reset output follows the sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mcu_reset <= 1'b1;
    end else begin
      mcu_reset <= (state_next != RSO_RUN);
    end
  end

  // remembers the kind of entry for the options init and the mode selection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      forced_reg <= 1'b0;
      lvd_entry_reg <= 1'b0;
    end else if (state_reg == RSO_RUN && any_src) begin
      forced_reg <= src_force;
      lvd_entry_reg <= src_lvd;
    end
  end

  // ---------------------------------------------------------------
  // cause capture and options init requests
  // ---------------------------------------------------------------

  // flags latched in the cycle the reset is entered
  assign bus.cap = (state_reg == RSO_RUN) && any_src;
  assign bus.forced = src_force;
  assign bus.lvd_src = src_lvd;
  assign bus.cause_src = {1'b0, src_pin, src_wdog, src_illegal_opcode_flag, src_illegal_address_flag, 1'b0, src_lvd, 1'b0};

  // options reload as the internal reset is released
  assign bus.opt_init = (state_reg == RSO_RELEASE);
  assign bus.opt_full = lvd_entry_reg;
  assign bus.opt_wr = wr_opts;
  assign bus.opt_wdata = acc_wdata;

  rso_cause_latch u_cause (
    .core_clk (core_clk),
    .rst (rst),
    .cz (bus.cause_mp)
  );

  rso_opts_once u_opts (
    .core_clk (core_clk),
    .rst (rst),
    .op (bus.opts_mp)
  );

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  // read data mux; unmapped index reads zero
  always_comb begin
    rdata_next = 8'h00;
    case (acc_sel)
      REG_IDX_STATUS: begin
        rdata_next = bus.status;
      end
      REG_IDX_FORCE: begin
        rdata_next = FORCE_READ_VAL;
      end
      REG_IDX_OPTS: begin
        rdata_next = bus.opt_val;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // registered read data, held until the next read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_rdata <= 8'h00;
    end else if (rd_any) begin
      acc_rdata <= rdata_next;
    end
  end

  // status copy for the rest of the chip
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_cause_status <= STATUS_POR_VAL;
    end else begin
      reset_cause_status <= bus.status;
    end
  end

  // ---------------------------------------------------------------
  // watchdog and sleep control
  // ---------------------------------------------------------------

  // write to the status address restarts the watchdog only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      watchdog_restart <= 1'b0;
    end else begin
      watchdog_restart <= wr_status || state_reg != RSO_RUN;
    end
  end

  // sleep granted only when permitted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sleep_enter <= 1'b0;
    end else begin
      sleep_enter <= exec_sleep && bus.opt_val[OPT_SLEEP] && state_reg == RSO_RUN;
    end
  end

  // ---------------------------------------------------------------
  // option outputs
  // ---------------------------------------------------------------

  // option bits driven to the rest of the chip
  always_ff @(posedge core_clk) begin
    if (rst) begin
      watchdog_enable <= OPT_RESET_VAL[OPT_WDOG_EN];
      watchdog_timeout_select <= OPT_RESET_VAL[OPT_WDOG_TSEL];
      sleep_permit <= OPT_RESET_VAL[OPT_SLEEP];
      debug_pin_enable <= OPT_RESET_VAL[OPT_DBG_PIN];
      reset_pin_enable <= OPT_RESET_VAL[OPT_RST_PIN];
      reset_pin_pullup <= OPT_RESET_VAL[OPT_RST_PIN];
    end else begin
      watchdog_enable <= bus.opt_val[OPT_WDOG_EN];
      watchdog_timeout_select <= bus.opt_val[OPT_WDOG_TSEL];
      sleep_permit <= bus.opt_val[OPT_SLEEP];
      debug_pin_enable <= bus.opt_val[OPT_DBG_PIN];
      reset_pin_enable <= bus.opt_val[OPT_RST_PIN];
      reset_pin_pullup <= bus.opt_val[OPT_RST_PIN];
    end
  end

  // ---------------------------------------------------------------
  // mode selection at release
  // ---------------------------------------------------------------

  // debug pin low at release of a forced reset selects background mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      background_debug_mode <= 1'b0;
    end else if (state_reg == RSO_RELEASE) begin
      background_debug_mode <= forced_reg && !dbg_sync;
    end
  end

endmodule
